// file: design/flash_protect_pkg.sv
// Constants and types shared by the flash protection logic.
package flash_protect_pkg;

   localparam int unsigned CLK_PERIOD_NS = 25;

   localparam int unsigned WDOG_LIMIT_MS = 64;
   localparam int unsigned WDOG_CYCLES = (WDOG_LIMIT_MS * 1000000) / CLK_PERIOD_NS;

   localparam int unsigned FLASH_STEP_US = 10;
   localparam int unsigned FLASH_STEP_CYCLES = (FLASH_STEP_US * 1000) / CLK_PERIOD_NS;

   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_IND = 2'h1;
   localparam logic [1:0] MODE_ASSIST = 2'h2;
   localparam logic [1:0] MODE_FLASH = 2'h3;

   localparam logic [1:0] EXT_OFF = 2'h0;
   localparam logic [1:0] EXT_TXMASK = 2'h1;
   localparam logic [1:0] EXT_TORCH = 2'h2;

   localparam logic OUT_ON_RST = 1'b0;
   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic [1:0] EXT_RST = 2'h0;
   localparam logic CONST_V_RST = 1'b0;
   localparam logic GAIN_RST = 1'b0;
   localparam logic TRIG_EN_RST = 1'b0;
   localparam logic TRIG_STYLE_RST = 1'b0;
   localparam logic DUAL_RST = 1'b0;
   localparam logic [7:0] FLASH_LIMIT_RST = 8'h00;

   localparam int unsigned FLT_OVP = 0;
   localparam int unsigned FLT_SHORT = 1;
   localparam int unsigned FLT_OVERHEAT = 2;
   localparam int unsigned FLT_TXMASK = 3;
   localparam int unsigned FLT_TIMEOUT = 4;
   localparam int unsigned FLT_W = 5;

   localparam int unsigned ASYNC_W = 15;

   typedef enum logic [1:0] {
      FL_IDLE = 2'b00,
      FL_RUN = 2'b01,
      FL_DONE = 2'b10
   } flash_state_t;

endpackage

// file: design/wdog_if.sv
// Signals between the protection controller and its clock-low watchdog.
`timescale 1ns/1ps
`default_nettype none
interface wdog_if;
   logic arm;
   logic scl_high;
   logic expire;
   modport ctrl (output arm, output scl_high, input expire);
   modport timer (input arm, input scl_high, output expire);
endinterface
`default_nettype wire

// file: design/level_sync.sv
// Three-stage synchroniser whose output changes once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module level_sync
   import flash_protect_pkg::*;
#(
   parameter int unsigned N = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [N-1:0] d,
   output logic [N-1:0] q
);
   logic [N-1:0] s1_reg;
   logic [N-1:0] s2_reg;
   logic [N-1:0] s3_reg;
   logic [N-1:0] q_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // Disagreeing stages hold the old value, so a single glitch never passes.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q_reg <= '0;
      end else begin
         q_reg <= (s2_reg & s3_reg) | (q_reg & (s2_reg | s3_reg));
      end
   end

   assign q = q_reg;
endmodule
`default_nettype wire

// file: design/scl_low_watchdog.sv
// Counter that flags a clock line held low for too long.
`timescale 1ns/1ps
`default_nettype none
module scl_low_watchdog
   import flash_protect_pkg::*;
#(
   parameter int unsigned LIMIT = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   wdog_if.timer wd
);
   localparam int unsigned CW = $clog2(LIMIT + 1);
   localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

   logic [CW-1:0] cnt_reg;
   logic expire_reg;

   // A high clock line clears the count at once, so only an unbroken low stretch can expire.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= '0;
      end else if (!wd.arm || wd.scl_high || cnt_reg == LAST) begin
         cnt_reg <= '0; // [R21]
      end else begin
         cnt_reg <= cnt_reg + 1'b1; // [R21]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         expire_reg <= 1'b0;
      end else begin
         expire_reg <= wd.arm && !wd.scl_high && cnt_reg == LAST; // [R15]
      end
   end

   assign wd.expire = expire_reg;
endmodule
`default_nettype wire

// file: design/flash_protect_ctrl.sv
// Fault protection, flash timing and power-off watchdog of the LED flash driver.
//
// Notes on behaviour
// [R1] Overvoltage with low headroom stops everything, flags.
// [R2] Overvoltage without low headroom raises no fault.
// [R3] Constant-voltage mode suppresses overvoltage detection.
// [R4] Short check only after startup, above current.
// [R5] Shorted LED stops converter, sinks, sets flag.
// [R6] Dual LED: one short disables only it.
// [R7] Overheat stops converter and sinks, sets flag.
// [R8] Cooling below hysteresis restarts driver automatically.
// [R9] Constant-voltage mode: no restart after overheat.
// [R10] Transmit mask during flash sets its flag.
// [R11] Flash timer starts with every flash.
// [R12] Pin-held flash beyond limit stops, flags overrun.
// [R13] Timer-defined flash sets overrun flag at end; the code sets it only when the trigger is disabled.
// [R14] Supply low holds shutdown and default registers.
// [R15] Active mode with clock low too long shuts down.
// [R16] First clock rise ends shutdown immediately.
// [R17] Watchdog shutdown resets registers, zero sink current.
// [R18] Torch and indicator have no duration timeout.
// [R19] Fault read clears fault flags.
// [R20] Protection fault clears enable, mode, pin function.
// [R21] Watchdog counter cleared while clock is high.
`timescale 1ns/1ps
`default_nettype none
module flash_protect_ctrl
   import flash_protect_pkg::*;
#(
   parameter int unsigned WDOG_LIMIT = WDOG_CYCLES,
   parameter int unsigned FLASH_STEP = FLASH_STEP_CYCLES
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic SUPPLY_LOW,
   input wire logic SCL,
   input wire logic STROBE,
   input wire logic TXMASK,
   input wire logic VOUT_MAX,
   input wire logic [1:0] HEADROOM_LOW,
   input wire logic [1:0] LED_LOW,
   input wire logic [1:0] CUR_TRIP_STD,
   input wire logic [1:0] CUR_TRIP_RAISED,
   input wire logic TEMP_HOT,
   input wire logic BOOST_READY,
   input wire logic CFG_WR,
   input wire logic CFG_OUT_ON,
   input wire logic [1:0] CFG_MODE,
   input wire logic [1:0] CFG_EXT_FUNC,
   input wire logic CFG_CONST_V,
   input wire logic CFG_GAIN_RAISE,
   input wire logic CFG_TRIG_EN,
   input wire logic CFG_TRIG_STYLE,
   input wire logic CFG_DUAL_LED,
   input wire logic [7:0] CFG_FLASH_LIMIT,
   input wire logic FAULT_RD,
   output logic OUT_ON,
   output logic [1:0] MODE,
   output logic [1:0] EXT_FUNC,
   output logic CONV_EN,
   output logic [1:0] SINK_EN,
   output logic FLASH_ON,
   output logic SHUTDOWN,
   output logic FAULT_OVP,
   output logic FAULT_SHORT,
   output logic FAULT_OVERHEAT,
   output logic FAULT_TXMASK,
   output logic FAULT_TIMEOUT
);
   localparam int unsigned PW = $clog2(FLASH_STEP + 1);
   localparam logic [PW-1:0] PRE_LAST = PW'(FLASH_STEP - 1);

   function automatic logic [1:0] cur_monitored(input logic raise, input logic [1:0] std_trip,
                                                input logic [1:0] raised_trip);
      cur_monitored = raise ? raised_trip : std_trip;
   endfunction

   function automatic logic mode_active(input logic on, input logic [1:0] m);
      mode_active = on && (m != MODE_OFF);
   endfunction

   logic [ASYNC_W-1:0] async_raw;
   logic [ASYNC_W-1:0] async_s;
   logic supply_low_s;
   logic scl_s;
   logic strobe_s;
   logic txmask_s;
   logic vout_max_s;
   logic [1:0] headroom_low_s;
   logic [1:0] led_low_s;
   logic [1:0] cur_std_s;
   logic [1:0] cur_raised_s;
   logic temp_hot_s;
   logic boost_ready_s;

   logic out_on_reg;
   logic [1:0] mode_reg;
   logic [1:0] ext_reg;
   logic const_v_reg;
   logic gain_reg;
   logic trig_en_reg;
   logic trig_style_reg;
   logic dual_reg;
   logic [7:0] limit_reg;
   logic shutdown_reg;
   logic scl_prev_reg;
   logic strobe_prev_reg;
   logic ot_hold_reg;
   logic [1:0] sink_off_reg;
   logic conv_en_reg;
   logic [1:0] sink_en_reg;
   logic flash_on_reg;
   logic [FLT_W-1:0] faults_reg;
   flash_state_t fl_state_reg;
   flash_state_t fl_state_next;
   logic [PW-1:0] pre_reg;
   logic [7:0] step_reg;

   logic soft_rst;
   logic scl_rise;
   logic strobe_rise;
   logic ov_det;
   logic [1:0] short_hit;
   logic short_one;
   logic short_all;
   logic ot_event;
   logic timer_hit;
   logic pin_flash;
   logic overrun;
   logic flash_end;
   logic prot_stop;
   logic ext_torch;
   logic run_ok;
   logic conv_next;
   logic [1:0] sink_off_next;
   logic [FLT_W-1:0] fault_set;

   wdog_if wd ();

   assign async_raw = {SUPPLY_LOW, SCL, STROBE, TXMASK, VOUT_MAX, HEADROOM_LOW, LED_LOW,
                       CUR_TRIP_STD, CUR_TRIP_RAISED, TEMP_HOT, BOOST_READY};

   level_sync #(.N(ASYNC_W)) u_sync (
      .clk(CLK),
      .rst_n(RST_N),
      .d(async_raw),
      .q(async_s)
   );

   assign {supply_low_s, scl_s, strobe_s, txmask_s, vout_max_s, headroom_low_s, led_low_s,
           cur_std_s, cur_raised_s, temp_hot_s, boost_ready_s} = async_s;

   assign wd.arm = mode_active(out_on_reg, mode_reg); // [R15]
   assign wd.scl_high = scl_s;

   scl_low_watchdog #(.LIMIT(WDOG_LIMIT)) u_wdog (
      .clk(CLK),
      .rst_n(RST_N),
      .wd(wd.timer)
   );

   assign scl_rise = scl_s && !scl_prev_reg;
   assign strobe_rise = strobe_s && !strobe_prev_reg;
   assign soft_rst = supply_low_s || shutdown_reg; // [R14] [R17]

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         scl_prev_reg <= 1'b0;
         strobe_prev_reg <= 1'b0;
      end else begin
         scl_prev_reg <= scl_s;
         strobe_prev_reg <= strobe_s;
      end
   end

   // A supply too low to trust keeps the block asleep, even across clock activity.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         shutdown_reg <= 1'b0;
      end else if (supply_low_s || wd.expire) begin
         shutdown_reg <= 1'b1; // [R14] [R15]
      end else if (scl_rise) begin
         shutdown_reg <= 1'b0; // [R16]
      end
   end

   assign ov_det = conv_en_reg && vout_max_s && (|headroom_low_s) && !const_v_reg; // [R1] [R2] [R3]

   assign short_hit = {2{conv_en_reg && boost_ready_s}} & sink_en_reg & led_low_s &
                      cur_monitored(gain_reg, cur_std_s, cur_raised_s); // [R4]
   assign short_one = dual_reg && (short_hit == 2'b01 || short_hit == 2'b10); // [R6]
   assign short_all = (|short_hit) && !short_one; // [R5]

   assign ot_event = temp_hot_s && !ot_hold_reg; // [R7]

   assign timer_hit = (fl_state_reg == FL_RUN) && pre_reg == PRE_LAST && step_reg == limit_reg;
   assign pin_flash = trig_en_reg && trig_style_reg;
   assign overrun = timer_hit && pin_flash; // [R12]
   assign flash_end = timer_hit && !pin_flash; // [R13]

   // Overheat in constant-voltage mode clears the enable so cooling cannot restart it.
   assign prot_stop = ov_det || short_all || overrun || (ot_event && const_v_reg); // [R20] [R9]

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         out_on_reg <= OUT_ON_RST;
         mode_reg <= MODE_RST;
         ext_reg <= EXT_RST;
         const_v_reg <= CONST_V_RST;
         gain_reg <= GAIN_RST;
         trig_en_reg <= TRIG_EN_RST;
         trig_style_reg <= TRIG_STYLE_RST;
         dual_reg <= DUAL_RST;
         limit_reg <= FLASH_LIMIT_RST;
      end else if (soft_rst) begin
         out_on_reg <= OUT_ON_RST; // [R14] [R17]
         mode_reg <= MODE_RST;
         ext_reg <= EXT_RST;
         const_v_reg <= CONST_V_RST;
         gain_reg <= GAIN_RST;
         trig_en_reg <= TRIG_EN_RST;
         trig_style_reg <= TRIG_STYLE_RST;
         dual_reg <= DUAL_RST;
         limit_reg <= FLASH_LIMIT_RST;
      end else if (prot_stop) begin
         out_on_reg <= 1'b0; // [R20]
         mode_reg <= MODE_OFF;
         ext_reg <= EXT_OFF;
      end else if (CFG_WR) begin
         out_on_reg <= CFG_OUT_ON;
         mode_reg <= CFG_MODE;
         ext_reg <= CFG_EXT_FUNC;
         const_v_reg <= CFG_CONST_V;
         gain_reg <= CFG_GAIN_RAISE;
         trig_en_reg <= CFG_TRIG_EN;
         trig_style_reg <= CFG_TRIG_STYLE;
         dual_reg <= CFG_DUAL_LED;
         limit_reg <= CFG_FLASH_LIMIT;
      end else if (flash_end) begin
         out_on_reg <= 1'b0;
         mode_reg <= MODE_OFF;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ot_hold_reg <= 1'b0;
      end else if (temp_hot_s) begin
         ot_hold_reg <= 1'b1; // [R7]
      end else begin
         ot_hold_reg <= 1'b0; // [R8]
      end
   end

   always_comb begin
      fl_state_next = fl_state_reg;
      case (fl_state_reg)
         FL_IDLE: begin
            if (out_on_reg && mode_reg == MODE_FLASH && !soft_rst) begin
               if (!trig_en_reg || (trig_style_reg && strobe_s) || (!trig_style_reg && strobe_rise)) begin
                  fl_state_next = FL_RUN; // [R11]
               end
            end
         end
         FL_RUN: begin
            if (soft_rst || prot_stop || !out_on_reg || mode_reg != MODE_FLASH) begin
               fl_state_next = FL_IDLE;
            end else if ((pin_flash && !strobe_s) || timer_hit) begin
               fl_state_next = FL_DONE;
            end
         end
         FL_DONE: begin
            if (!strobe_s || !out_on_reg || mode_reg != MODE_FLASH) begin
               fl_state_next = FL_IDLE;
            end
         end
         default: begin
            fl_state_next = FL_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         fl_state_reg <= FL_IDLE;
      end else begin
         fl_state_reg <= fl_state_next;
      end
   end

   // The timer only exists in the flash state, so steady torch light never times out.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         pre_reg <= '0;
         step_reg <= 8'h00;
      end else if (fl_state_reg != FL_RUN) begin
         pre_reg <= '0; // [R18]
         step_reg <= 8'h00;
      end else if (pre_reg == PRE_LAST) begin
         pre_reg <= '0; // [R11]
         step_reg <= step_reg + 8'h01;
      end else begin
         pre_reg <= pre_reg + 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         flash_on_reg <= 1'b0;
      end else begin
         flash_on_reg <= fl_state_next == FL_RUN;
      end
   end

   assign ext_torch = mode_reg == MODE_OFF && ext_reg == EXT_TORCH && txmask_s;
   assign run_ok = mode_active(out_on_reg, mode_reg) &&
                   (mode_reg != MODE_FLASH || fl_state_next == FL_RUN);
   assign conv_next = !soft_rst && !prot_stop && !temp_hot_s && !ot_hold_reg &&
                      !short_all && (run_ok || ext_torch); // [R1] [R5] [R7] [R12]

   assign sink_off_next = (soft_rst || !(out_on_reg || ext_torch)) ? 2'b00 :
                          (sink_off_reg | (short_one ? short_hit : 2'b00)); // [R6]

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         sink_off_reg <= 2'b00;
         conv_en_reg <= 1'b0;
         sink_en_reg <= 2'b00;
      end else begin
         sink_off_reg <= sink_off_next;
         conv_en_reg <= conv_next;
         sink_en_reg <= {2{conv_next}} & ~sink_off_next; // [R17]
      end
   end

   always_comb begin
      fault_set = '0;
      fault_set[FLT_OVP] = ov_det; // [R1]
      fault_set[FLT_SHORT] = |short_hit; // [R5] [R6]
      fault_set[FLT_OVERHEAT] = ot_event; // [R7]
      fault_set[FLT_TXMASK] = flash_on_reg && ext_reg == EXT_TXMASK && txmask_s; // [R10]
      fault_set[FLT_TIMEOUT] = overrun || (flash_end && !trig_en_reg); // [R12] [R13]
   end

   // A fault arriving in the same cycle as the read survives it.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         faults_reg <= '0;
      end else if (soft_rst) begin
         faults_reg <= '0; // [R14]
      end else begin
         faults_reg <= fault_set | (faults_reg & {FLT_W{!FAULT_RD}}); // [R19]
      end
   end

   assign OUT_ON = out_on_reg;
   assign MODE = mode_reg;
   assign EXT_FUNC = ext_reg;
   assign CONV_EN = conv_en_reg;
   assign SINK_EN = sink_en_reg;
   assign FLASH_ON = flash_on_reg;
   assign SHUTDOWN = shutdown_reg;
   assign FAULT_OVP = faults_reg[FLT_OVP];
   assign FAULT_SHORT = faults_reg[FLT_SHORT];
   assign FAULT_OVERHEAT = faults_reg[FLT_OVERHEAT];
   assign FAULT_TXMASK = faults_reg[FLT_TXMASK];
   assign FAULT_TIMEOUT = faults_reg[FLT_TIMEOUT];

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   AST_OVP_STOP: assert property (ov_det |=> !CONV_EN && SINK_EN == 2'b00 && FAULT_OVP && !OUT_ON) // [R1]
      else $error("overvoltage did not stop the output");
   AST_OVP_HEADROOM: assert property ($rose(FAULT_OVP) |-> $past(|headroom_low_s)) // [R2]
      else $error("overvoltage flag without low headroom");
   AST_OVP_CV: assert property ($rose(FAULT_OVP) |-> $past(!const_v_reg)) // [R3]
      else $error("overvoltage flag in constant-voltage mode");
   AST_SHORT_GATE: assert property ($rose(FAULT_SHORT) |-> $past(boost_ready_s && conv_en_reg)) // [R4]
      else $error("short flagged before converter startup");
   AST_SHORT_STOP: assert property (short_all |=> !CONV_EN && FAULT_SHORT && MODE == MODE_OFF) // [R5]
      else $error("short circuit did not stop converter");
   AST_SHORT_ONE: assert property (short_one |=> ((SINK_EN & $past(short_hit)) == 2'b00) && FAULT_SHORT) // [R6]
      else $error("single shorted sink still enabled");
   AST_OT_STOP: assert property (temp_hot_s |=> !CONV_EN ##1 !CONV_EN) // [R7]
      else $error("converter running while hot");
   AST_OT_CV: assert property (ot_event && const_v_reg && !soft_rst |=> !OUT_ON) // [R9]
      else $error("constant-voltage overheat left output enabled");
   AST_TXMASK: assert property (flash_on_reg && ext_reg == EXT_TXMASK && txmask_s |=> FAULT_TXMASK) // [R10]
      else $error("transmit mask during flash not flagged");
   AST_OVERRUN: assert property (overrun |=> FAULT_TIMEOUT && !CONV_EN && !FLASH_ON && MODE == MODE_OFF) // [R12]
      else $error("flash overrun not handled");
   AST_SUPPLY: assert property (supply_low_s |=> SHUTDOWN && !OUT_ON && SINK_EN == 2'b00) // [R14]
      else $error("supply low did not hold shutdown");
   AST_WDOG: assert property (wd.expire |=> SHUTDOWN ##1 (!OUT_ON && MODE == MODE_OFF && SINK_EN == 2'b00)) // [R17]
      else $error("watchdog shutdown did not reset");
   AST_WAKE: assert property (SHUTDOWN && scl_rise && !supply_low_s |=> !SHUTDOWN) // [R16]
      else $error("clock rise did not end shutdown");
   AST_FAULT_CLR: assert property (FAULT_RD && fault_set == '0 && !soft_rst |=> faults_reg == '0) // [R19]
      else $error("fault read did not clear flags");

   COV_OVP: cover property (ov_det ##1 FAULT_OVP);
   COV_SHORT_ONE: cover property (short_one ##1 FAULT_SHORT && CONV_EN);
   COV_OVERRUN: cover property (overrun);
   COV_WAKE: cover property (wd.expire ##[1:50] (scl_rise && SHUTDOWN));
endmodule
`default_nettype wire

// file: verification/scl_host_model.sv
// Behavioural host that drives the serial clock line seen by the protection block.
`timescale 1ns/1ps
`default_nettype none
module scl_host_model
   import flash_protect_pkg::*;
(
   input wire logic alive,
   input wire logic busy,
   output logic scl
);
   logic phase;
   // The odd start offset keeps the 200 ns link clock away from the block's clock edges.
   initial begin
      phase = 1'b1;
      #37;
      forever begin
         #100;
         phase = busy ? ~phase : 1'b1;
      end
   end
   // A host that has lost its supply lets the line fall, since its pull-up has no supply either.
   assign scl = alive ? phase : 1'b0;
endmodule
`default_nettype wire

// file: verification/led_flash_fault_and_shutdown_logic_tb.sv
// Self-checking bench for the flash protection and shutdown logic.
`timescale 1ns/1ps
`default_nettype none
module led_flash_fault_and_shutdown_logic_tb
   import flash_protect_pkg::*;
;
   localparam int unsigned WD = 20;
   logic clk, rst_n, supply_low, scl, strobe, txmask, vout_max, temp_hot, boost_ready, cfg_wr, cfg_on, cfg_cv;
   logic cfg_gain, cfg_te, cfg_ts, cfg_dual, fault_rd, out_on, conv_en, flash_on, shutdown, host_alive, host_busy;
   logic f_ovp, f_short, f_hot, f_tx, f_to;
   logic [1:0] headroom_low, led_low, trip_std, trip_raised, cfg_mode, cfg_ext, mode, ext_func, sink_en;
   logic [7:0] cfg_limit, run_v, set_v, flg_v;
   int bad_count, compares, cycles;

   assign run_v = {3'h0, shutdown, flash_on, conv_en, sink_en};
   assign set_v = {3'h0, out_on, mode, ext_func};
   assign flg_v = {3'h0, f_to, f_tx, f_hot, f_short, f_ovp};

   flash_protect_ctrl #(.WDOG_LIMIT(WD), .FLASH_STEP(4)) dut_u (
      .CLK(clk), .RST_N(rst_n), .SUPPLY_LOW(supply_low), .SCL(scl), .STROBE(strobe), .TXMASK(txmask),
      .VOUT_MAX(vout_max), .HEADROOM_LOW(headroom_low), .LED_LOW(led_low), .CUR_TRIP_STD(trip_std),
      .CUR_TRIP_RAISED(trip_raised), .TEMP_HOT(temp_hot), .BOOST_READY(boost_ready), .CFG_WR(cfg_wr),
      .CFG_OUT_ON(cfg_on), .CFG_MODE(cfg_mode), .CFG_EXT_FUNC(cfg_ext), .CFG_CONST_V(cfg_cv),
      .CFG_GAIN_RAISE(cfg_gain), .CFG_TRIG_EN(cfg_te), .CFG_TRIG_STYLE(cfg_ts), .CFG_DUAL_LED(cfg_dual),
      .CFG_FLASH_LIMIT(cfg_limit), .FAULT_RD(fault_rd), .OUT_ON(out_on), .MODE(mode), .EXT_FUNC(ext_func),
      .CONV_EN(conv_en), .SINK_EN(sink_en), .FLASH_ON(flash_on), .SHUTDOWN(shutdown), .FAULT_OVP(f_ovp),
      .FAULT_SHORT(f_short), .FAULT_OVERHEAT(f_hot), .FAULT_TXMASK(f_tx), .FAULT_TIMEOUT(f_to));

   scl_host_model host_u (.alive(host_alive), .busy(host_busy), .scl(scl));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // The whole run needs about 650 cycles, so this ceiling only trips on a hang.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         test_done();
      end
   end

   task automatic ticks(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
      end
   endtask

   task automatic cfg(input logic on, input logic [1:0] md, input logic [1:0] ex, input logic cv, input logic te,
                      input logic ts, input logic du, input logic [7:0] lim);
      {cfg_on, cfg_mode, cfg_ext, cfg_cv, cfg_te, cfg_ts, cfg_dual, cfg_limit} = {on, md, ex, cv, te, ts, du, lim};
      cfg_wr = 1'b1;
      ticks(1);
      cfg_wr = 1'b0;
      ticks(2);
   endtask

   // Fault inputs must be quiet first, because a fault in the read cycle wins over the clear.
   task automatic rd_faults();
      ticks(6);
      fault_rd = 1'b1;
      ticks(1);
      fault_rd = 1'b0;
      ticks(1);
      chk("fault flags", 8'h00, flg_v);
   endtask

   task automatic test_end(input string nm);
      $display("Test %s finished", nm);
   endtask

   initial begin
      {rst_n, supply_low, strobe, txmask, vout_max, temp_hot, boost_ready, cfg_wr, fault_rd, cfg_gain} = '0;
      {headroom_low, led_low, trip_std, trip_raised} = '0;
      {cfg_on, cfg_mode, cfg_ext, cfg_cv, cfg_te, cfg_ts, cfg_dual, cfg_limit} = '0;
      host_alive = 1'b1;
      host_busy = 1'b0;
      ticks(2);
      rst_n = 1'b1;
      ticks(1);
      chk("reset state", 8'h00, run_v | set_v | flg_v);
      boost_ready = 1'b1;
      cfg(1, MODE_ASSIST, EXT_OFF, 0, 0, 0, 0, 8'h00);
      chk("assist run", 8'h07, run_v);
      vout_max = 1'b1;
      ticks(8);
      chk("ovp no headroom", 8'h07, run_v | flg_v);
      headroom_low = 2'h1;
      ticks(8);
      chk("ovp flag", 8'h01, flg_v);
      chk("ovp stop", 8'h00, run_v);
      chk("ovp settings", 8'h00, set_v);
      {vout_max, headroom_low} = '0;
      rd_faults();
      cfg(1, MODE_ASSIST, EXT_OFF, 1, 0, 0, 0, 8'h00);
      {vout_max, headroom_low} = 3'h7;
      ticks(8);
      chk("ovp const v", 8'h07, run_v | flg_v);
      {vout_max, headroom_low} = '0;
      ticks(6);
      test_end("overvoltage");
      cfg_gain = 1'b1;
      cfg(1, MODE_ASSIST, EXT_OFF, 0, 0, 0, 0, 8'h00);
      {led_low, trip_std} = 4'h5;
      ticks(8);
      chk("short below raised", 8'h00, flg_v);
      {boost_ready, trip_raised} = 3'h1;
      ticks(8);
      chk("short before startup", 8'h00, flg_v);
      boost_ready = 1'b1;
      ticks(8);
      chk("short flag", 8'h02, flg_v);
      chk("short stop", 8'h00, run_v);
      {led_low, trip_std, trip_raised} = '0;
      rd_faults();
      cfg_gain = 1'b0;
      cfg(1, MODE_ASSIST, EXT_OFF, 0, 0, 0, 1, 8'h00);
      {led_low, trip_std} = 4'hA;
      ticks(8);
      chk("dual short flag", 8'h02, flg_v);
      chk("dual short run", 8'h05, run_v);
      {led_low, trip_std} = '0;
      cfg(0, MODE_OFF, EXT_OFF, 0, 0, 0, 0, 8'h00);
      rd_faults();
      test_end("short");
      cfg(1, MODE_ASSIST, EXT_OFF, 0, 0, 0, 0, 8'h00);
      temp_hot = 1'b1;
      ticks(8);
      chk("hot flag", 8'h04, flg_v);
      chk("hot stop", 8'h00, run_v);
      temp_hot = 1'b0;
      ticks(8);
      chk("cooled restart", 8'h07, run_v);
      rd_faults();
      cfg(1, MODE_ASSIST, EXT_OFF, 1, 0, 0, 0, 8'h00);
      temp_hot = 1'b1;
      ticks(8);
      temp_hot = 1'b0;
      ticks(8);
      chk("const v no restart", 8'h00, run_v);
      rd_faults();
      test_end("overheat");
      cfg(1, MODE_FLASH, EXT_OFF, 0, 0, 0, 0, 8'h02);
      chk("flash start", 8'h0F, run_v);
      ticks(8);
      chk("flash mid", 8'h0F, run_v);
      ticks(8);
      chk("flash end", 8'h00, run_v | set_v);
      chk("flash end flag", 8'h10, flg_v);
      rd_faults();
      cfg(1, MODE_FLASH, EXT_TXMASK, 0, 0, 0, 0, 8'h0A);
      txmask = 1'b1;
      ticks(8);
      chk("txmask flag", 8'h08, flg_v);
      chk("txmask no stop", 8'h0F, run_v);
      txmask = 1'b0;
      ticks(45);
      rd_faults();
      cfg(1, MODE_FLASH, EXT_OFF, 0, 1, 1, 0, 8'h02);
      strobe = 1'b1;
      ticks(8);
      chk("pin flash run", 8'h0F, run_v);
      ticks(14);
      chk("pin overrun stop", 8'h00, run_v | set_v);
      chk("pin overrun flag", 8'h10, flg_v);
      strobe = 1'b0;
      rd_faults();
      cfg(1, MODE_FLASH, EXT_OFF, 0, 1, 0, 0, 8'h04);
      chk("edge flash waits", 8'h00, run_v);
      strobe = 1'b1;
      ticks(8);
      chk("edge flash run", 8'h0F, run_v);
      ticks(24);
      chk("edge flash end", 8'h00, run_v | flg_v);
      strobe = 1'b0;
      test_end("flash");
      cfg(0, MODE_OFF, EXT_TORCH, 0, 0, 0, 0, 8'h00);
      txmask = 1'b1;
      ticks(8);
      chk("pin torch", 8'h07, run_v);
      txmask = 1'b0;
      cfg(1, MODE_IND, EXT_OFF, 0, 0, 0, 0, 8'h00);
      host_busy = 1'b1;
      ticks(200);
      chk("indicator lasting", 8'h07, run_v);
      host_busy = 1'b0;
      host_alive = 1'b0;
      ticks(WD + 12);
      chk("clock low shutdown", 8'h10, run_v);
      chk("shutdown settings", 8'h00, set_v);
      cfg(1, MODE_ASSIST, EXT_OFF, 0, 0, 0, 0, 8'h00);
      chk("write in shutdown", 8'h10, set_v | run_v);
      host_alive = 1'b1;
      ticks(8);
      chk("clock rise wakeup", 8'h00, run_v);
      cfg(0, MODE_IND, EXT_OFF, 0, 0, 0, 0, 8'h00);
      host_alive = 1'b0;
      ticks(WD + 12);
      chk("disarmed watchdog", 8'h00, run_v);
      host_alive = 1'b1;
      ticks(8);
      test_end("watchdog");
      cfg(1, MODE_ASSIST, EXT_OFF, 0, 0, 0, 0, 8'h00);
      supply_low = 1'b1;
      ticks(8);
      chk("supply low", 8'h10, set_v | run_v);
      cfg(1, MODE_ASSIST, EXT_OFF, 0, 0, 0, 0, 8'h00);
      chk("write supply low", 8'h00, set_v);
      supply_low = 1'b0;
      host_busy = 1'b1;
      ticks(16);
      cfg(1, MODE_ASSIST, EXT_OFF, 0, 0, 0, 0, 8'h00);
      chk("supply back", 8'h18, set_v);
      test_end("supply");
      test_done();
   end
endmodule
`default_nettype wire
